// ---- ssmc_pkg.sv ----
package ssmc_pkg;
   localparam int unsigned CLK_MHZ  = 200;
   localparam int unsigned SLOW_US  = 150;
   localparam int unsigned FAST_US  = 2;
   localparam int unsigned SLOW_CYC = SLOW_US * CLK_MHZ;
   localparam int unsigned FAST_CYC = FAST_US * CLK_MHZ;
   localparam int unsigned CNT_W    = 15;

   localparam logic [7:0] ADR_LOW_CTL  = 8'h00;
   localparam logic [7:0] ADR_HIGH_CTL = 8'h04;
   localparam logic [7:0] ADR_CLK_CTL  = 8'h08;
   localparam logic [7:0] ADR_STATUS   = 8'h0C;
   localparam logic [7:0] ADR_IRQ_STAT = 8'h10;
   localparam logic [7:0] ADR_IRQ_MASK = 8'h14;

   localparam logic [5:0] CTL_RST    = 6'h11;
   localparam logic [2:0] DIV_RST    = 3'h0;
   localparam logic [2:0] DIV_BY_TWO = 3'h1;
   localparam int unsigned DIV_CNT_W = 7;

   localparam int unsigned IRQ_W    = 3;
   localparam int unsigned IRQ_LOW  = 0;
   localparam int unsigned IRQ_HIGH = 1;
   localparam int unsigned IRQ_WAKE = 2;

   typedef struct packed {
      logic mon_fp;
      logic mon_en;
      logic auto_ctl;
      logic full_perf;
      logic keep;
      logic en;
   } ssmc_side_s;

   typedef enum logic [1:0] {
      CMP_OFF    = 2'h0,
      CMP_NORMAL = 2'h1,
      CMP_FULL   = 2'h3
   } ssmc_cmp_e;

   typedef struct packed {
      ssmc_cmp_e sup;
      ssmc_cmp_e mon;
   } ssmc_cmp_s;

   typedef enum logic [1:0] {
      PM_ACTIVE = 2'h0,
      PM_DEEP   = 2'h1,
      PM_WAKE   = 2'h3
   } ssmc_pm_e;
endpackage

// ---- ssmc_top.sv ----
module ssmc_top #(
   parameter int unsigned SLOW_CYC = ssmc_pkg::SLOW_CYC
) (
   // clock and reset
   input  wire logic        REF_CLK,
   input  wire logic        SRST,
   input  wire logic        CE,
   // wishbone slave
   input  wire logic        WB_CYC_I,
   input  wire logic        WB_STB_I,
   input  wire logic        WB_WE_I,
   input  wire logic [7:0]  WB_ADR_I,
   input  wire logic [3:0]  WB_SEL_I,
   input  wire logic [31:0] WB_DAT_I,
   output logic      [31:0] WB_DAT_O,
   output logic             WB_ACK_O,
   // power mode request, high while deep modes are wanted
   input  wire logic        DEEP_REQ,
   // comparator states and clocking
   output ssmc_pkg::ssmc_cmp_s LOW_CMP,
   output ssmc_pkg::ssmc_cmp_s HIGH_CMP,
   output logic             CPU_EXEC_MASK,
   output logic             MAIN_CLK_EN,
   output logic             SUB_CLK_EN,
   output logic             IRQ
);
   localparam logic [ssmc_pkg::CNT_W-1:0] SLOW_LD = ssmc_pkg::CNT_W'(SLOW_CYC);
   localparam logic [ssmc_pkg::CNT_W-1:0] FAST_LD = ssmc_pkg::CNT_W'(ssmc_pkg::FAST_CYC);

   ssmc_pkg::ssmc_side_s            low_ctl;
   ssmc_pkg::ssmc_side_s            high_ctl;
   logic [2:0]                      clk_div;
   logic                            sub_from_osc;
   logic [ssmc_pkg::IRQ_W-1:0]      irq_stat;
   logic [ssmc_pkg::IRQ_W-1:0]      irq_mask;
   ssmc_pkg::ssmc_pm_e              pm;
   logic [ssmc_pkg::CNT_W-1:0]      low_cnt;
   logic [ssmc_pkg::CNT_W-1:0]      high_cnt;
   logic [ssmc_pkg::CNT_W-1:0]      wake_cnt;
   logic [ssmc_pkg::DIV_CNT_W-1:0]  div_cnt;
   logic                            req;
   logic                            wr;
   logic                            low_wr;
   logic                            high_wr;
   logic                            pm_edge;
   logic                            wake_slow;
   logic                            low_done;
   logic                            high_done;
   logic                            wake_done;
   logic [ssmc_pkg::IRQ_W-1:0]      irq_set;
   logic [ssmc_pkg::DIV_CNT_W-1:0]  div_mask;
   logic [31:0]                     next_rdata;
   ssmc_pkg::ssmc_cmp_s             next_low;
   ssmc_pkg::ssmc_cmp_s             next_high;
   ssmc_pkg::ssmc_side_s            wr_ctl;

   function automatic ssmc_pkg::ssmc_cmp_e act_state(logic en, logic fp);
      if (!en)
         return ssmc_pkg::CMP_OFF;
      return fp ? ssmc_pkg::CMP_FULL : ssmc_pkg::CMP_NORMAL;
   endfunction

   function automatic ssmc_pkg::ssmc_cmp_e sup_state(ssmc_pkg::ssmc_side_s c, logic deep);
      if (!deep)
         return act_state(c.en, c.full_perf);
      if (c.auto_ctl)
         return (c.en && c.keep && c.full_perf) ? ssmc_pkg::CMP_NORMAL : ssmc_pkg::CMP_OFF;
      return c.keep ? act_state(c.en, c.full_perf) : ssmc_pkg::CMP_OFF;
   endfunction

   function automatic ssmc_pkg::ssmc_cmp_e mon_state(ssmc_pkg::ssmc_side_s c, logic deep);
      if (!deep || !c.auto_ctl)
         return act_state(c.mon_en, c.mon_fp);
      return (c.mon_en && c.mon_fp) ? ssmc_pkg::CMP_NORMAL : ssmc_pkg::CMP_OFF;
   endfunction

   // bus decode: a write lands at the edge where ack is sampled
   assign req     = WB_CYC_I && WB_STB_I;
   assign wr      = req && WB_ACK_O && WB_WE_I && WB_SEL_I[0];
   assign low_wr  = wr && (WB_ADR_I == ssmc_pkg::ADR_LOW_CTL);
   assign high_wr = wr && (WB_ADR_I == ssmc_pkg::ADR_HIGH_CTL);
   assign wr_ctl  = WB_DAT_I[5:0];

   always_ff @(posedge REF_CLK) begin
      if (SRST)
         WB_ACK_O <= 1'b0;
      else if (CE)
         WB_ACK_O <= req && !WB_ACK_O;
   end

   always_comb begin
      next_rdata = 32'h0000_0000;
      unique case (WB_ADR_I)
         ssmc_pkg::ADR_LOW_CTL:  next_rdata[5:0] = low_ctl;
         ssmc_pkg::ADR_HIGH_CTL: next_rdata[5:0] = high_ctl;
         ssmc_pkg::ADR_CLK_CTL:  next_rdata[3:0] = {sub_from_osc, clk_div};
         ssmc_pkg::ADR_STATUS:
            next_rdata[12:0] = {CPU_EXEC_MASK, HIGH_CMP, LOW_CMP, pm,
                                high_cnt != '0, low_cnt != '0};
         ssmc_pkg::ADR_IRQ_STAT: next_rdata[ssmc_pkg::IRQ_W-1:0] = irq_stat;
         ssmc_pkg::ADR_IRQ_MASK: next_rdata[ssmc_pkg::IRQ_W-1:0] = irq_mask;
         default:                next_rdata = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge REF_CLK) begin
      if (SRST)
         WB_DAT_O <= 32'h0000_0000;
      else if (CE && req && !WB_ACK_O)
         WB_DAT_O <= next_rdata;
   end

   // control registers
   always_ff @(posedge REF_CLK) begin
      if (SRST) begin
         low_ctl      <= ssmc_pkg::CTL_RST;
         high_ctl     <= ssmc_pkg::CTL_RST;
         clk_div      <= ssmc_pkg::DIV_RST;
         sub_from_osc <= 1'b1;
         irq_mask     <= '0;
      end else if (CE && wr) begin
         if (low_wr)
            low_ctl <= WB_DAT_I[5:0];
         if (high_wr)
            high_ctl <= WB_DAT_I[5:0];
         if (WB_ADR_I == ssmc_pkg::ADR_CLK_CTL)
            {sub_from_osc, clk_div} <= WB_DAT_I[3:0];
         if (WB_ADR_I == ssmc_pkg::ADR_IRQ_MASK)
            irq_mask <= WB_DAT_I[ssmc_pkg::IRQ_W-1:0];
      end
   end

   // power mode sequence
   always_ff @(posedge REF_CLK) begin
      if (SRST)
         pm <= ssmc_pkg::PM_ACTIVE;
      else if (CE) begin
         unique case (pm)
            ssmc_pkg::PM_ACTIVE: if (DEEP_REQ) pm <= ssmc_pkg::PM_DEEP;
            ssmc_pkg::PM_DEEP:   if (!DEEP_REQ) pm <= ssmc_pkg::PM_WAKE;
            ssmc_pkg::PM_WAKE:   if (wake_cnt == 'd1) pm <= ssmc_pkg::PM_ACTIVE;
            default:             pm <= ssmc_pkg::PM_ACTIVE;
         endcase
      end
   end

   assign pm_edge = (pm == ssmc_pkg::PM_ACTIVE && DEEP_REQ)
                 || (pm == ssmc_pkg::PM_DEEP && !DEEP_REQ);

   // slow mask - any low comparator in normal state
   assign wake_slow = act_state(low_ctl.en, low_ctl.full_perf) == ssmc_pkg::CMP_NORMAL
                   || act_state(low_ctl.mon_en, low_ctl.mon_fp) == ssmc_pkg::CMP_NORMAL;

   always_ff @(posedge REF_CLK) begin
      if (SRST)
         wake_cnt <= '0;
      else if (CE) begin
         if (pm == ssmc_pkg::PM_DEEP && !DEEP_REQ)
            wake_cnt <= wake_slow ? SLOW_LD : FAST_LD;
         else if (wake_cnt != '0)
            wake_cnt <= wake_cnt - 1'b1;
      end
   end

   assign CPU_EXEC_MASK = (pm == ssmc_pkg::PM_WAKE);

   // settle timers restart on write or on entering or leaving deep mode
   // a write settles for the performance bit it writes, not the old one
   always_ff @(posedge REF_CLK) begin
      if (SRST)
         low_cnt <= '0;
      else if (CE) begin
         if (low_wr)
            low_cnt <= wr_ctl.full_perf ? FAST_LD : SLOW_LD;
         else if (pm_edge)
            low_cnt <= low_ctl.full_perf ? FAST_LD : SLOW_LD;
         else if (low_cnt != '0)
            low_cnt <= low_cnt - 1'b1;
      end
   end

   always_ff @(posedge REF_CLK) begin
      if (SRST)
         high_cnt <= '0;
      else if (CE) begin
         if (high_wr)
            high_cnt <= wr_ctl.full_perf ? FAST_LD : SLOW_LD;
         else if (pm_edge)
            high_cnt <= high_ctl.full_perf ? FAST_LD : SLOW_LD;
         else if (high_cnt != '0)
            high_cnt <= high_cnt - 1'b1;
      end
   end

   always_comb begin
      next_low.sup  = sup_state(low_ctl, pm == ssmc_pkg::PM_DEEP);
      next_low.mon  = mon_state(low_ctl, pm == ssmc_pkg::PM_DEEP);
      next_high.sup = sup_state(high_ctl, pm == ssmc_pkg::PM_DEEP);
      next_high.mon = mon_state(high_ctl, pm == ssmc_pkg::PM_DEEP);
   end

   always_ff @(posedge REF_CLK) begin
      if (SRST) begin
         LOW_CMP  <= '{ssmc_pkg::CMP_OFF, ssmc_pkg::CMP_OFF};
         HIGH_CMP <= '{ssmc_pkg::CMP_OFF, ssmc_pkg::CMP_OFF};
      end else if (CE) begin
         LOW_CMP  <= next_low;
         HIGH_CMP <= next_high;
      end
   end

   // main clock enable divided by two to the field value
   assign div_mask = ssmc_pkg::DIV_CNT_W'(8'hFF >> (4'd8 - {1'b0, clk_div}));

   always_ff @(posedge REF_CLK) begin
      if (SRST) begin
         div_cnt     <= '0;
         MAIN_CLK_EN <= 1'b0;
      end else if (CE) begin
         div_cnt     <= div_cnt + 1'b1;
         MAIN_CLK_EN <= (div_cnt & div_mask) == '0;
      end
   end

   // oscillator-fed subsystem clock is never held during wake-up
   always_ff @(posedge REF_CLK) begin
      if (SRST)
         SUB_CLK_EN <= 1'b1;
      else if (CE)
         SUB_CLK_EN <= sub_from_osc || (pm != ssmc_pkg::PM_WAKE);
   end

   // interrupt events; a set beats a write-one clear
   assign low_done  = low_cnt == 'd1;
   assign high_done = high_cnt == 'd1;
   assign wake_done = (pm == ssmc_pkg::PM_WAKE) && (wake_cnt == 'd1);
   assign irq_set   = {wake_done, high_done, low_done};

   always_ff @(posedge REF_CLK) begin
      if (SRST)
         irq_stat <= '0;
      else if (CE) begin
         if (wr && WB_ADR_I == ssmc_pkg::ADR_IRQ_STAT)
            irq_stat <= (irq_stat & ~WB_DAT_I[ssmc_pkg::IRQ_W-1:0]) | irq_set;
         else
            irq_stat <= irq_stat | irq_set;
      end
   end

   assign IRQ = |(irq_stat & irq_mask);

   chk_low_sup_active: assert property (@(posedge REF_CLK) disable iff (SRST)
      CE && pm == ssmc_pkg::PM_ACTIVE && low_ctl.en && !low_ctl.full_perf
      |=> LOW_CMP.sup == ssmc_pkg::CMP_NORMAL)
      else $error("low supervisor not normal in active mode");

   chk_low_manual_off: assert property (@(posedge REF_CLK) disable iff (SRST)
      CE && pm == ssmc_pkg::PM_DEEP && !low_ctl.auto_ctl && !low_ctl.keep
      |=> LOW_CMP.sup == ssmc_pkg::CMP_OFF)
      else $error("low supervisor not off in deep mode");

   chk_low_auto_drop: assert property (@(posedge REF_CLK) disable iff (SRST)
      CE && pm == ssmc_pkg::PM_DEEP && low_ctl == 6'h0F
      |=> LOW_CMP.sup == ssmc_pkg::CMP_NORMAL)
      else $error("low supervisor did not drop to normal");

   chk_wake_fast_mask: assert property (@(posedge REF_CLK) disable iff (SRST)
      CE && pm == ssmc_pkg::PM_DEEP && !DEEP_REQ && !wake_slow
      |=> wake_cnt == FAST_LD && CPU_EXEC_MASK)
      else $error("fast wake mask length wrong");

   chk_wake_slow_mask: assert property (@(posedge REF_CLK) disable iff (SRST)
      CE && pm == ssmc_pkg::PM_DEEP && !DEEP_REQ && wake_slow
      |=> wake_cnt == SLOW_LD ##1 CPU_EXEC_MASK)
      else $error("slow wake mask length wrong");

   chk_low_mon_keep: assert property (@(posedge REF_CLK) disable iff (SRST)
      CE && pm == ssmc_pkg::PM_DEEP && !low_ctl.auto_ctl && low_ctl.mon_en
      |=> LOW_CMP.mon != ssmc_pkg::CMP_OFF)
      else $error("low monitor lost its state");

   chk_high_sup_active: assert property (@(posedge REF_CLK) disable iff (SRST)
      CE && pm != ssmc_pkg::PM_DEEP && high_ctl.en && high_ctl.full_perf
      |=> HIGH_CMP.sup == ssmc_pkg::CMP_FULL)
      else $error("high supervisor not full");

   chk_high_manual_off: assert property (@(posedge REF_CLK) disable iff (SRST)
      CE && pm == ssmc_pkg::PM_DEEP && !high_ctl.auto_ctl && !high_ctl.keep
      |=> HIGH_CMP.sup == ssmc_pkg::CMP_OFF)
      else $error("high supervisor not off in deep mode");

   chk_high_auto_off: assert property (@(posedge REF_CLK) disable iff (SRST)
      CE && pm == ssmc_pkg::PM_DEEP && high_ctl.auto_ctl && !high_ctl.full_perf
      |=> HIGH_CMP.sup == ssmc_pkg::CMP_OFF)
      else $error("high supervisor on under auto control");

   chk_high_mon_off: assert property (@(posedge REF_CLK) disable iff (SRST)
      CE && !high_ctl.mon_en |=> HIGH_CMP.mon == ssmc_pkg::CMP_OFF)
      else $error("disabled high monitor is on");

   chk_settle_load: assert property (@(posedge REF_CLK) disable iff (SRST)
      CE && (low_wr || pm_edge)
      |=> low_cnt == (low_ctl.full_perf ? FAST_LD : SLOW_LD))
      else $error("low settle delay wrong");

   chk_settle_flag: assert property (@(posedge REF_CLK) disable iff (SRST)
      CE && high_wr |=> high_cnt != '0)
      else $error("high settle flag not set after write");

   chk_sub_clk_raw: assert property (@(posedge REF_CLK) disable iff (SRST)
      CE && sub_from_osc |=> SUB_CLK_EN)
      else $error("oscillator subsystem clock was masked");

   chk_div_two: assert property (@(posedge REF_CLK) disable iff (SRST)
      CE && clk_div == ssmc_pkg::DIV_BY_TWO && $past(CE) && $past(clk_div) == clk_div
      |=> MAIN_CLK_EN != $past(MAIN_CLK_EN))
      else $error("divide by two not alternating");

   chk_low_sup_full: assert property (@(posedge REF_CLK) disable iff (SRST)
      CE && pm != ssmc_pkg::PM_DEEP && low_ctl.en && low_ctl.full_perf
      |=> LOW_CMP.sup == ssmc_pkg::CMP_FULL)
      else $error("low supervisor not full in active mode");

   chk_low_sup_off: assert property (@(posedge REF_CLK) disable iff (SRST)
      CE && pm != ssmc_pkg::PM_DEEP && !low_ctl.en
      |=> LOW_CMP.sup == ssmc_pkg::CMP_OFF)
      else $error("disabled low supervisor is on");

   chk_low_manual_keep: assert property (@(posedge REF_CLK) disable iff (SRST)
      CE && pm == ssmc_pkg::PM_DEEP && !low_ctl.auto_ctl && low_ctl.keep && low_ctl.en
      && low_ctl.full_perf |=> LOW_CMP.sup == ssmc_pkg::CMP_FULL)
      else $error("low supervisor did not keep full state");

   chk_low_auto_off: assert property (@(posedge REF_CLK) disable iff (SRST)
      CE && pm == ssmc_pkg::PM_DEEP && low_ctl.auto_ctl
      && !(low_ctl.en && low_ctl.keep && low_ctl.full_perf)
      |=> LOW_CMP.sup == ssmc_pkg::CMP_OFF)
      else $error("low supervisor on under auto control");

   chk_low_mon_auto: assert property (@(posedge REF_CLK) disable iff (SRST)
      CE && pm == ssmc_pkg::PM_DEEP && low_ctl.auto_ctl && low_ctl.mon_en && !low_ctl.mon_fp
      |=> LOW_CMP.mon == ssmc_pkg::CMP_OFF)
      else $error("low monitor on under auto control");

   chk_high_sup_off: assert property (@(posedge REF_CLK) disable iff (SRST)
      CE && pm != ssmc_pkg::PM_DEEP && !high_ctl.en
      |=> HIGH_CMP.sup == ssmc_pkg::CMP_OFF)
      else $error("disabled high supervisor is on");

   chk_high_manual_keep: assert property (@(posedge REF_CLK) disable iff (SRST)
      CE && pm == ssmc_pkg::PM_DEEP && !high_ctl.auto_ctl && high_ctl.keep && high_ctl.en
      && !high_ctl.full_perf |=> HIGH_CMP.sup == ssmc_pkg::CMP_NORMAL)
      else $error("high supervisor did not keep normal state");

   chk_high_auto_drop: assert property (@(posedge REF_CLK) disable iff (SRST)
      CE && pm == ssmc_pkg::PM_DEEP && high_ctl.auto_ctl && high_ctl.en && high_ctl.keep
      && high_ctl.full_perf |=> HIGH_CMP.sup == ssmc_pkg::CMP_NORMAL)
      else $error("high supervisor did not drop to normal");

   chk_wake_mask_end: assert property (@(posedge REF_CLK) disable iff (SRST)
      CE && pm == ssmc_pkg::PM_WAKE && wake_cnt == 'd1 |=> !CPU_EXEC_MASK)
      else $error("wake mask outlived its count");

   chk_low_settle_flag: assert property (@(posedge REF_CLK) disable iff (SRST)
      CE && low_wr |=> low_cnt != '0)
      else $error("low settle flag not set after write");

   chk_high_settle_load: assert property (@(posedge REF_CLK) disable iff (SRST)
      CE && (high_wr || pm_edge)
      |=> high_cnt == (high_ctl.full_perf ? FAST_LD : SLOW_LD))
      else $error("high settle delay wrong");

   chk_settle_irq_set: assert property (@(posedge REF_CLK) disable iff (SRST)
      CE && low_done |=> irq_stat[ssmc_pkg::IRQ_LOW])
      else $error("low settle done event lost");
endmodule

// ---- ssmc_top_test.sv ----
module ssmc_top_test;
   timeunit 1ns;
   timeprecision 100ps;

   localparam int unsigned SLOW = 600;
   localparam int unsigned FAST = ssmc_pkg::FAST_CYC;

   logic                ref_clk = 1'b0;
   logic                srst    = 1'b1;
   logic                cyc     = 1'b0;
   logic                stb     = 1'b0;
   logic                we      = 1'b0;
   logic                deep    = 1'b0;
   logic                ce      = 1'b1;
   logic [7:0]          adr     = 8'h00;
   logic [3:0]          sel     = 4'hF;
   logic [31:0]         wdat    = 32'h0;
   logic [31:0]         rdat;
   logic [31:0]         dat_o;
   logic                ack;
   logic                mask;
   logic                mclk;
   logic                sclk;
   logic                irq;
   ssmc_pkg::ssmc_cmp_s lcmp;
   ssmc_pkg::ssmc_cmp_s hcmp;
   int                  err_total = 0;
   int                  compares  = 0;
   int                  cnt       = 0;
   int                  t0;
   int                  t1;
   int                  k;
   logic [5:0]          cases [9] = '{6'h00, 6'h03, 6'h05, 6'h07, 6'h0F, 6'h0B, 6'h30, 6'h38, 6'h18};

   always #2.5 ref_clk = ~ref_clk;

   always @(posedge ref_clk) cnt <= cnt + 1;

   ssmc_top #(.SLOW_CYC(SLOW)) ssmc_top_i (
      .REF_CLK       (ref_clk),
      .SRST          (srst),
      .CE            (ce),
      .WB_CYC_I      (cyc),
      .WB_STB_I      (stb),
      .WB_WE_I       (we),
      .WB_ADR_I      (adr),
      .WB_SEL_I      (sel),
      .WB_DAT_I      (wdat),
      .WB_DAT_O      (dat_o),
      .WB_ACK_O      (ack),
      .DEEP_REQ      (deep),
      .LOW_CMP       (lcmp),
      .HIGH_CMP      (hcmp),
      .CPU_EXEC_MASK (mask),
      .MAIN_CLK_EN   (mclk),
      .SUB_CLK_EN    (sclk),
      .IRQ           (irq)
   );

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         err_total++;
         $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic conclude;
      if (err_total == 0 && compares > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk);
   endtask

   // one classic cycle, released at the ack edge
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] s = 4'hF);
      int n;
      n = 0;
      @(posedge ref_clk);
      cyc  <= 1'b1;
      stb  <= 1'b1;
      sel  <= s;
      we   <= w;
      adr  <= a;
      wdat <= d;
      do begin
         @(posedge ref_clk);
         n++;
      end while (ack !== 1'b1 && n < 50);
      if (ack !== 1'b1) check({31'h0, ack}, 32'h1);
      rdat = dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
      we  <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      wb(1'b0, a, 32'h0);
      check(rdat, e);
   endtask

   // poll until both settle flags are clear
   task automatic settle(output int t);
      int n;
      n = 0;
      do begin
         wb(1'b0, ssmc_pkg::ADR_STATUS, 32'h0);
         n++;
      end while (rdat[1:0] !== 2'b00 && n < 400);
      t = cnt;
   endtask

   function automatic ssmc_pkg::ssmc_cmp_e act(input logic en, input logic fp);
      return !en ? ssmc_pkg::CMP_OFF : (fp ? ssmc_pkg::CMP_FULL : ssmc_pkg::CMP_NORMAL);
   endfunction

   function automatic ssmc_pkg::ssmc_cmp_s deep_exp(input logic [5:0] c);
      ssmc_pkg::ssmc_cmp_s r;
      if (c[3]) begin
         r.sup = (c[0] & c[1] & c[2]) ? ssmc_pkg::CMP_NORMAL : ssmc_pkg::CMP_OFF;
         r.mon = (c[4] & c[5]) ? ssmc_pkg::CMP_NORMAL : ssmc_pkg::CMP_OFF;
      end else begin
         r.sup = c[1] ? act(c[0], c[2]) : ssmc_pkg::CMP_OFF;
         r.mon = act(c[4], c[5]);
      end
      return r;
   endfunction

   // program both sides, check active, deep and wake-up behaviour
   task automatic deep_run(input logic [5:0] c, input logic sub_exp);
      int   n;
      int   ne;
      logic sl;
      ssmc_pkg::ssmc_cmp_s a;
      a  = '{sup: act(c[0], c[2]), mon: act(c[4], c[5])};
      ne = (a.sup == ssmc_pkg::CMP_NORMAL || a.mon == ssmc_pkg::CMP_NORMAL) ? SLOW : FAST;
      sl = 1'b1;
      wb(1'b1, ssmc_pkg::ADR_LOW_CTL, {26'h0, c});
      wb(1'b1, ssmc_pkg::ADR_HIGH_CTL, {26'h0, c});
      settle(n);
      check({28'h0, lcmp}, {28'h0, a});
      check({28'h0, hcmp}, {28'h0, a});
      deep <= 1'b1;
      tick(4);
      check({28'h0, lcmp}, {28'h0, deep_exp(c)});
      check({28'h0, hcmp}, {28'h0, deep_exp(c)});
      deep <= 1'b0;
      for (n = 0; n < 10 && mask !== 1'b1; n++) @(posedge ref_clk);
      n = 0;
      while (mask === 1'b1 && n < 2000) begin
         if (sclk !== 1'b1) sl = 1'b0;
         n++;
         @(posedge ref_clk);
      end
      check(32'(n), 32'(ne));
      check({31'h0, sl}, {31'h0, sub_exp});
   endtask

   initial begin
      tick(2);
      srst <= 1'b0;
      tick(2);
      rd(ssmc_pkg::ADR_LOW_CTL, 32'h11);
      rd(ssmc_pkg::ADR_HIGH_CTL, 32'h11);
      rd(ssmc_pkg::ADR_CLK_CTL, 32'h8);
      rd(ssmc_pkg::ADR_IRQ_MASK, 32'h0);
      check({28'h0, lcmp}, 32'h5);
      wb(1'b1, 8'h18, 32'hFF);
      rd(8'h18, 32'h0);
      wb(1'b1, ssmc_pkg::ADR_LOW_CTL, 32'h3F, 4'h0);
      rd(ssmc_pkg::ADR_LOW_CTL, 32'h11);
      settle(t1);
      wb(1'b1, ssmc_pkg::ADR_LOW_CTL, 32'h15);
      t0 = cnt;
      settle(t1);
      check({31'h0, (t1 - t0 >= FAST && t1 - t0 <= FAST + 8)}, 32'h1);
      wb(1'b1, ssmc_pkg::ADR_LOW_CTL, 32'h11);
      t0 = cnt;
      settle(t1);
      check({31'h0, (t1 - t0 >= SLOW && t1 - t0 <= SLOW + 8)}, 32'h1);
      wb(1'b1, ssmc_pkg::ADR_LOW_CTL, 32'h11);
      t0 = cnt;
      ce <= 1'b0;
      tick(100);
      ce <= 1'b1;
      settle(t1);
      check({31'h0, (t1 - t0 >= SLOW + 100 && t1 - t0 <= SLOW + 108)}, 32'h1);
      tick(1);
      check({31'h0, irq}, 32'h0);
      rd(ssmc_pkg::ADR_IRQ_STAT, 32'h1);
      wb(1'b1, ssmc_pkg::ADR_IRQ_MASK, 32'h1);
      tick(1);
      check({31'h0, irq}, 32'h1);
      wb(1'b1, ssmc_pkg::ADR_IRQ_STAT, 32'h1);
      tick(1);
      check({31'h0, irq}, 32'h0);
      rd(ssmc_pkg::ADR_IRQ_STAT, 32'h0);
      for (int d = 0; d < 4; d++) begin
         wb(1'b1, ssmc_pkg::ADR_CLK_CTL, 32'h8 | 32'(d));
         tick(4);
         k = 0;
         repeat (8) begin
            @(posedge ref_clk);
            if (mclk === 1'b1) k++;
         end
         check(32'(k), 32'(8 >> d));
      end
      foreach (cases[i]) deep_run(cases[i], 1'b1);
      wb(1'b1, ssmc_pkg::ADR_CLK_CTL, {29'h0, ssmc_pkg::DIV_BY_TWO});
      deep_run(6'h03, 1'b0);
      rd(ssmc_pkg::ADR_IRQ_STAT, 32'h7);
      conclude;
   end

   initial begin
      #250000;
      err_total++;
      conclude;
   end
endmodule
